/* File: core/pabd_pin_mux.sv */
// Pin multiplexer for port A bits 6 and 7, port B and port D bit 0.
// Operation
// - Config field picks port A6 or commit
// - Asserted commit input commits FIFO packet
// - Commit active level set by polarity bit
// - Config and alt bit pick A7 role
// - Flag role drives selected FIFO flag
// - Chip select gates all FIFO strobes
// - Port B pins are port or data
// - Data lines driven out, sampled in
// - Port D0 is bit 8 when wordwide
// - Port mode has per-bit output enable, except A6 and A7 share one
`timescale 1ns/1ps
module pabd_pin_mux (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [1:0] interface_cfg_sel_i,
  input wire logic [7:0] fifo_pin_polarity_cfg_i,
  input wire logic [7:0] porta_alt_func_cfg_i,
  input wire logic [7:0] endpoint_fifo_cfg_i,
  input wire logic port_wr_i,
  input wire logic [9:0] port_out_i,
  input wire logic [9:0] port_oe_i,
  output logic [9:0] port_in_o,
  input wire logic fifo_flag_d_i,
  input wire logic bus_drive_i,
  input wire logic [8:0] bus_out_i,
  output logic [8:0] bus_in_o,
  output logic packet_commit_o,
  output logic fifo_select_o,
  output logic [1:0] porta_hi_out_o,
  output logic [1:0] porta_hi_oe_o,
  input wire logic [1:0] porta_hi_in_i,
  output logic [7:0] portb_out_o,
  output logic [7:0] portb_oe_o,
  input wire logic [7:0] portb_in_i,
  output logic portd_bit0_out_o,
  output logic portd_bit0_oe_o,
  input wire logic portd_bit0_in_i
);
  // Port register index layout: 0..7 port B, 8 port D bit 0, 9 port A bits 6 and 7.
  // Port A bits 6 and 7 share latch bit 9 in their port roles, so software cannot
  // drive them to different levels; that saves a latch at the cost of flexibility.
  // Both port A outputs are registered once more, so they follow port B by one cycle.

  // All state of the mux: port and bus output latches, enables, port A outputs and a commit edge tracker.
  typedef struct packed {
    logic [9:0] port_out;
    logic [9:0] port_oe;
    logic [8:0] bus_out;
    logic bus_oe;
    logic [1:0] a_out;
    logic [1:0] a_oe;
    logic commit_prev;
    logic commit;
  } pabd_state_type;

  pabd_state_type state;
  pabd_state_type next_state;

  // Synchronised pin levels: [7:0] port B, [8] port D0, [9] A6, [10] A7.
  logic [10:0] pins_sync;

  pabd_sync #(
    .WIDTH(11)
  ) u_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i({porta_hi_in_i, portd_bit0_in_i, portb_in_i}),
    .sync_o(pins_sync)
  );

  // Decoded modes and pin roles, combinational from configuration inputs and synchronised pins.
  logic bus_mode;
  logic fifo_mode;
  logic wide_mode;
  logic a7_flag;
  logic a7_select;
  logic commit_level;
  logic select_active;

  // True when the interface field selects either bus mode.
  function automatic logic pabd_is_bus(input logic [1:0] sel);
    pabd_is_bus = (sel == pabd_pkg::IFCFG_WAVE) || (sel == pabd_pkg::IFCFG_FIFO);
  endfunction : pabd_is_bus

  // Mode decode; reserved code is treated as port mode to keep pins safe.
  always_comb begin
    bus_mode = pabd_is_bus(interface_cfg_sel_i);
    fifo_mode = (interface_cfg_sel_i == pabd_pkg::IFCFG_FIFO);
    wide_mode = bus_mode && endpoint_fifo_cfg_i[pabd_pkg::WORDWIDE_BIT];
    // Alt bit set gives the flag output; clear gives chip select in FIFO mode.
    a7_flag = bus_mode && porta_alt_func_cfg_i[pabd_pkg::ALT_A7_BIT];
    a7_select = fifo_mode && !porta_alt_func_cfg_i[pabd_pkg::ALT_A7_BIT];
    // Polarity bit set means the commit input is active high.
    // A change of polarity while the pin is idle looks like an edge and commits once;
    // software should change the polarity only outside slave FIFO mode.
    commit_level = pins_sync[9] ~^ fifo_pin_polarity_cfg_i[pabd_pkg::POL_COMMIT_BIT];
    // Without the chip-select role the FIFO is always selected.
    select_active = a7_select ? !pins_sync[10] : 1'b1;
  end

  // Next-state logic for every driven pin.
  always_comb begin
    next_state = state;
    // Port latches load whenever software writes; they keep value across mode changes.
    if (port_wr_i) begin
      next_state.port_out = port_out_i;
      next_state.port_oe = port_oe_i;
    end
    next_state.bus_out = bus_out_i;
    // Bus drive is refused while the chip select is inactive.
    next_state.bus_oe = bus_mode && bus_drive_i && select_active;
    // Port A bit 6: port pin unless FIFO mode takes it as a commit input.
    next_state.a_out[0] = state.port_out[9];
    next_state.a_oe[0] = fifo_mode ? 1'b0 : state.port_oe[9];
    // Port A bit 7: flag output, select input, or a port pin mirroring bit 6 register.
    if (a7_flag) begin
      next_state.a_out[1] = fifo_flag_d_i;
      next_state.a_oe[1] = 1'b1;
    end else if (a7_select) begin
      next_state.a_out[1] = 1'b0;
      next_state.a_oe[1] = 1'b0;
    end else begin
      next_state.a_out[1] = state.port_out[9];
      next_state.a_oe[1] = state.port_oe[9];
    end
    // Commit is one pulse on the inactive-to-active edge of the gated input.
    next_state.commit_prev = commit_level && fifo_mode && select_active;
    next_state.commit = next_state.commit_prev && !state.commit_prev;
  end

  // Register the state; reset leaves every pin an input with drivers off.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
      // The commit edge tracker starts as if the pin were already active, so the
      // zeroed synchroniser cannot fake an edge while it fills after reset.
      state.commit_prev <= pabd_pkg::COMMIT_IDLE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Pin drive selection per bit between the port latch and the data bus.
  always_comb begin
    portb_out_o = bus_mode ? state.bus_out[7:0] : state.port_out[7:0];
    portb_oe_o = bus_mode ? {8{state.bus_oe}} : state.port_oe[7:0];
    portd_bit0_out_o = wide_mode ? state.bus_out[8] : state.port_out[8];
    portd_bit0_oe_o = wide_mode ? state.bus_oe : state.port_oe[8];
    porta_hi_out_o = state.a_out;
    porta_hi_oe_o = state.a_oe;
    port_in_o = {pins_sync[9], pins_sync[8:0]};
    bus_in_o = {wide_mode ? pins_sync[8] : 1'b0, pins_sync[7:0]};
    packet_commit_o = state.commit;
    fifo_select_o = select_active && fifo_mode;
  end

  // Checks on the pin mux.
  // They watch registered pin controls, so most of them look one cycle after the cause.
  // All are disabled during reset, when the outputs are held at their reset values.
  chk_select_gates_bus: assert property (@(posedge clock_i) disable iff (reset_i)
    (a7_select && pins_sync[10]) |=> !state.bus_oe)
    else $error("bus driven while deselected");
  chk_commit_pulse_one: assert property (@(posedge clock_i) disable iff (reset_i)
    packet_commit_o |=> !packet_commit_o)
    else $error("commit longer than one cycle");
  chk_commit_needs_fifo: assert property (@(posedge clock_i) disable iff (reset_i)
    packet_commit_o |-> $past(fifo_mode))
    else $error("commit outside fifo mode");
  chk_commit_polarity: assert property (@(posedge clock_i) disable iff (reset_i)
    (packet_commit_o && $stable(fifo_pin_polarity_cfg_i)) |-> $past(commit_level))
    else $error("commit at wrong level");
  chk_flag_drives: assert property (@(posedge clock_i) disable iff (reset_i)
    a7_flag |=> (porta_hi_oe_o[1] && porta_hi_out_o[1] == $past(fifo_flag_d_i)))
    else $error("flag not driven");
  chk_select_is_input: assert property (@(posedge clock_i) disable iff (reset_i)
    a7_select |=> !porta_hi_oe_o[1])
    else $error("select pin driven");
  chk_portb_bus_oe: assert property (@(posedge clock_i) disable iff (reset_i)
    bus_mode |-> (portb_oe_o == {8{state.bus_oe}}))
    else $error("port b mux wrong");
  chk_pd0_narrow: assert property (@(posedge clock_i) disable iff (reset_i)
    !wide_mode |-> (portd_bit0_oe_o == state.port_oe[8]))
    else $error("pd0 left port role");
  chk_port_oe_load: assert property (@(posedge clock_i) disable iff (reset_i)
    (port_wr_i && !bus_mode) |=> !$stable(bus_mode) || portb_oe_o == $past(port_oe_i[7:0]))
    else $error("port enable not loaded");
  chk_bus_sample: assert property (@(posedge clock_i) disable iff (reset_i)
    bus_in_o[7:0] == pins_sync[7:0])
    else $error("bus sample wrong");

  // A dropped drive request must release the data pins at the next edge.
  chk_bus_drive_release: assert property (@(posedge clock_i) disable iff (reset_i)
    (bus_mode && !$past(bus_drive_i)) |-> (portb_oe_o == 8'h00))
    else $error("bus still driven after release");

  // In slave FIFO mode port A bit 6 is the commit input and is never driven.
  chk_a6_commit_input: assert property (@(posedge clock_i) disable iff (reset_i)
    fifo_mode |=> !porta_hi_oe_o[0])
    else $error("commit pin driven");

  // Outside slave FIFO mode port A bit 6 follows its port enable latch.
  chk_a6_port_follow: assert property (@(posedge clock_i) disable iff (reset_i)
    !fifo_mode |=> (porta_hi_oe_o[0] == $past(state.port_oe[9])))
    else $error("a6 port enable wrong");

  // A deselected FIFO never produces a commit.
  chk_select_no_commit: assert property (@(posedge clock_i) disable iff (reset_i)
    (a7_select && pins_sync[10]) |=> !packet_commit_o)
    else $error("commit while deselected");

  // Outside slave FIFO mode the commit output stays low.
  chk_commit_ports_idle: assert property (@(posedge clock_i) disable iff (reset_i)
    !fifo_mode |=> !packet_commit_o)
    else $error("commit in port mode");

  // In word-wide bus mode bit 8 is enabled together with the low byte.
  chk_pd0_wide_bus: assert property (@(posedge clock_i) disable iff (reset_i)
    wide_mode |-> (portd_bit0_oe_o == portb_oe_o[0]))
    else $error("bit 8 enable differs from low byte");

  // A port write shows on port B one cycle later while the mode stays port.
  chk_portb_port_load: assert property (@(posedge clock_i) disable iff (reset_i)
    (!bus_mode && $past(port_wr_i) && $stable(bus_mode)) |-> (portb_out_o == $past(port_out_i[7:0])))
    else $error("port b data not loaded");
endmodule : pabd_pin_mux

/* File: core/pabd_sync.sv */
// Two flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
module pabd_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  // State of the synchroniser held in one packed struct.
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pabd_sync_state_type;

  pabd_sync_state_type state;
  pabd_sync_state_type next_state;

  // The first stage feeds only the second; nothing else reads it.
  always_comb begin
    next_state = state;
    next_state.stage1 = async_i;
    next_state.stage2 = state.stage1;
  end

  // Register the chain; reset loads constants only.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_o = state.stage2;
endmodule : pabd_sync

/* File: shared/pabd_pkg.sv */
// Package with the pin mux constants and mode encodings.
package pabd_pkg;
  // Interface selection codes: 00 ports, 01 reserved, 10 waveform engine, 11 slave FIFO.
  localparam logic [1:0] IFCFG_PORTS = 2'h0;
  localparam logic [1:0] IFCFG_RSVD = 2'h1;
  localparam logic [1:0] IFCFG_WAVE = 2'h2;
  localparam logic [1:0] IFCFG_FIFO = 2'h3;
  // Bit position of packet-commit polarity in the polarity configuration.
  localparam int POL_COMMIT_BIT = 5;
  // Bit position of the alternate-function bit for port A bit 7.
  localparam int ALT_A7_BIT = 7;
  // Bit position of the word-wide bit in the endpoint FIFO configuration.
  localparam int WORDWIDE_BIT = 0;
  // Reset values: port registers clear, all drivers off.
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] OE_RESET = 8'h00;
  // Reset value of the commit edge tracker: treated as already active.
  localparam logic COMMIT_IDLE_RESET = 1'b1;
  // Cycles of synchroniser delay on every pin input.
  localparam int SYNC_STAGES = 2;
endpackage : pabd_pkg

/* File: sim/pabd_far_end.sv */
// Far-end model: the external master and the resolved level of each pin.
`timescale 1ns/1ps
module pabd_far_end (
  input wire logic clock_i,
  input wire logic [10:0] dev_out_i,
  input wire logic [10:0] dev_oe_i,
  input wire logic [10:0] far_out_i,
  input wire logic [10:0] far_oe_i,
  output logic [10:0] pin_o
);
  // Last resolved level; a released line shows its inverse, so a stale value never looks valid.
  logic [10:0] last = 11'h000;
  // The device wins, then the master's data, commit and select levels.
  assign pin_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & far_oe_i & far_out_i) | (~dev_oe_i & ~far_oe_i & ~last);
  // Remember the level of each line only while someone drives it, so a released line stays put.
  always @(posedge clock_i) begin
    last <= ((dev_oe_i | far_oe_i) & pin_o) | (~(dev_oe_i | far_oe_i) & last);
  end
endmodule : pabd_far_end

/* File: sim/pabd_pin_mux_bench.sv */
// Self-checking bench for the port A, B and D pin multiplexer.
`timescale 1ns/1ps
module pabd_pin_mux_bench;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] cfg = 2'h0;
  logic [7:0] pol = 8'h20;
  logic [7:0] alt = 8'h00;
  logic [7:0] epc = 8'h00;
  logic wr = 1'b0;
  logic flag = 1'b0;
  logic drv = 1'b0;
  logic [9:0] pout = 10'h000, poe = 10'h000, pin_rd;
  logic [8:0] bout = 9'h000, bin;
  logic [10:0] fout = 11'h000, foe = 11'h000, pins;
  logic commit, sel, d_out, d_oe;
  logic [1:0] a_out, a_oe;
  logic [7:0] b_out, b_oe;
  int fails = 0;
  int tests_run = 0;
  int commits = 0;
  // Free-running 200 MHz clock.
  always #2.5 clock_i = ~clock_i;
  pabd_pin_mux u_pabd_pin_mux (.clock_i(clock_i), .reset_i(reset_i), .interface_cfg_sel_i(cfg),
    .fifo_pin_polarity_cfg_i(pol), .porta_alt_func_cfg_i(alt), .endpoint_fifo_cfg_i(epc), .port_wr_i(wr),
    .port_out_i(pout), .port_oe_i(poe), .port_in_o(pin_rd), .fifo_flag_d_i(flag), .bus_drive_i(drv),
    .bus_out_i(bout), .bus_in_o(bin), .packet_commit_o(commit), .fifo_select_o(sel), .porta_hi_out_o(a_out),
    .porta_hi_oe_o(a_oe), .porta_hi_in_i(pins[10:9]), .portb_out_o(b_out), .portb_oe_o(b_oe),
    .portb_in_i(pins[7:0]), .portd_bit0_out_o(d_out), .portd_bit0_oe_o(d_oe), .portd_bit0_in_i(pins[8]));
  pabd_far_end u_pabd_far_end (.clock_i(clock_i), .dev_out_i({a_out, d_out, b_out}),
    .dev_oe_i({a_oe, d_oe, b_oe}), .far_out_i(fout), .far_oe_i(foe), .pin_o(pins));
  // Count commit pulses at falling edges; a level instead of a pulse shows up as too many.
  task automatic count_commits(input int n);
    repeat (n) begin
      @(negedge clock_i);
      if (commit === 1'b1) commits++;
    end
  endtask : count_commits
  // Compare one value and count it.
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask : tick
  // Port latch write: one-cycle strobe taken at the rising edge.
  task automatic pw(input logic [9:0] o, input logic [9:0] e);
    @(negedge clock_i);
    pout = o;
    poe = e;
    wr = 1'b1;
    @(negedge clock_i);
    wr = 1'b0;
  endtask : pw
  // Hold the commit pin idle, then give it one active spell and count pulses.
  task automatic commit_try(input logic act, input int n);
    fout[9] = ~act;
    tick(6);
    commits = 0;
    fout[9] = act;
    count_commits(6);
    fout[9] = ~act;
    count_commits(6);
    chk(11'(commits), 11'(n), "commit pulses");
  endtask : commit_try
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Watchdog: the tests need about 120 cycles, so 4000 means a hang.
  initial begin
    #20000;
    fails++;
    test_done();
  end
  initial begin
    tick(3);
    reset_i = 1'b0;
    chk({a_oe, d_oe, b_oe}, 11'h000, "reset oe");
    chk({a_out, d_out, b_out}, 11'h000, "reset out");
    $display("test reset done");
    // Port mode: per-bit enables, A6 and A7 share latch bit 9 and follow one cycle later.
    pw(10'h2a5, 10'h3f0);
    chk(11'(b_oe), 11'h0f0, "port b oe");
    tick(1);
    chk({a_oe, d_oe, b_oe}, 11'h7f0, "port oe");
    chk({a_out, d_out, b_out}, 11'h6a5, "port out");
    foe = 11'h0ff;
    fout = 11'h05a;
    tick(4);
    chk(11'(pin_rd), 11'h2aa, "port in");
    $display("test port mode done");
    // Slave FIFO mode takes A6 as the commit input and A7 as the select input.
    cfg = pabd_pkg::IFCFG_FIFO;
    tick(2);
    chk(11'(a_oe), 11'h000, "fifo a6 a7 inputs");
    // Select high refuses the bus drive, select low grants it.
    pw(10'h000, 10'h000);
    cfg = pabd_pkg::IFCFG_FIFO;
    foe = 11'h600;
    fout = 11'h400;
    drv = 1'b1;
    bout = 9'h1c3;
    tick(4);
    chk(11'({sel, b_oe}), 11'h000, "deselected drive");
    fout[10] = 1'b0;
    tick(4);
    chk(11'({sel, d_oe, b_oe}), 11'h2ff, "selected drive");
    chk(11'(b_out), 11'h0c3, "bus out");
    epc = 8'h01;
    tick(2);
    chk(11'({d_oe, d_out}), 11'h003, "wide bit 8");
    drv = 1'b0;
    foe = 11'h7ff;
    fout = 11'h13c;
    tick(4);
    chk(11'(bin), 11'h13c, "bus in");
    $display("test bus done");
    commit_try(1'b1, 1);
    pol = 8'h00;
    commit_try(1'b0, 1);
    fout[10] = 1'b1;
    commit_try(1'b0, 0);
    fout[10] = 1'b0;
    cfg = pabd_pkg::IFCFG_PORTS;
    commit_try(1'b0, 0);
    $display("test commit done");
    // Waveform mode drives the bus without a select; then A7 as a flag output.
    cfg = pabd_pkg::IFCFG_WAVE;
    drv = 1'b1;
    tick(4);
    chk(11'(b_oe), 11'h0ff, "wave drive");
    cfg = pabd_pkg::IFCFG_FIFO;
    alt = 8'h80;
    foe = 11'h3ff;
    flag = 1'b1;
    tick(4);
    chk(11'({a_oe[1], a_out[1]}), 11'h003, "flag high");
    flag = 1'b0;
    tick(2);
    chk(11'({a_oe[1], a_out[1]}), 11'h002, "flag low");
    $display("test flag done");
    // Mid-run reset in FIFO mode with an active-low commit pin idle high: drivers off, no stray commit.
    reset_i = 1'b1;
    tick(1);
    chk({a_oe, d_oe, b_oe}, 11'h000, "mid reset oe");
    reset_i = 1'b0;
    commits = 0;
    count_commits(6);
    chk(11'(commits), 11'h000, "no commit after reset");
    $display("test mid reset done");
    test_done();
  end
endmodule : pabd_pin_mux_bench
